//--- smp_pkg.sv
// constants for the serial management port: frame codes, field widths, timing
// assumes both ends include nothing else and reference names as smp_pkg::name
package smp_pkg;
  localparam logic [4:0]  PHY_ADDR      = 5'h10;
  localparam logic [1:0]  START_CODE    = 2'h1;
  localparam logic [1:0]  OP_READ       = 2'h2;
  localparam logic [1:0]  OP_WRITE      = 2'h1;
  localparam logic [1:0]  TA_WRITE      = 2'h2;
  localparam int          PRE_BITS      = 32;
  localparam int          ADDR_BITS     = 5;
  localparam int          DATA_BITS     = 16;
  localparam int          MDC_MAX_KHZ   = 2500;
  localparam int          SYS_CLK_KHZ   = 100000;
  // half period in system cycles, rounded up so the clock never exceeds its limit
  localparam int          MDC_HALF      = (SYS_CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ);
  localparam logic [15:0] DATA_RESET    = 16'h0000;
endpackage : smp_pkg

//--- smp_if.sv
// interface joining the station and the device over clock and data line
// assumes the bench reads mdio for the resolved line level
`timescale 1ns/1ps
interface smp_if;
  logic mdc;
  logic sta_mdio_o;
  logic sta_mdio_oe;
  logic dev_mdio_o;
  logic dev_mdio_oe;
  wire  mdio;
  // open line with pull-up: released means one
  assign mdio = sta_mdio_oe ? sta_mdio_o : (dev_mdio_oe ? dev_mdio_o : 1'b1);
  modport station (output mdc, output sta_mdio_o, output sta_mdio_oe, input mdio);
  modport device  (input mdc, output dev_mdio_o, output dev_mdio_oe, input mdio);
endinterface : smp_if

//--- smp_regfile.sv
// register array of 32 words kept in the device, written and read over frames
// assumes one clock domain, the management clock
`timescale 1ns/1ps
module smp_regfile (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        we_in,
  input  wire logic [4:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] rdata_out
);
  logic [15:0] mem_reg [32];
  genvar i;
  generate
    for (i = 0; i < 32; i++)
    begin : g_word
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
          mem_reg[i] <= smp_pkg::DATA_RESET;
        else if (we_in && addr_in == 5'(i))
          mem_reg[i] <= wdata_in;
      end
    end
  endgenerate
  assign rdata_out = mem_reg[addr_in];
endmodule : smp_regfile

//--- smp_device.sv
// device end: decodes frames on the management clock, answers reads, stores writes
// assumes the station supplies a clock that runs through each frame
`timescale 1ns/1ps
module smp_device (
  smp_if.device           bus,
  input  wire logic       rst_n_in,
  output logic [4:0]      last_reg_out,
  output logic            wr_seen_out
);
  typedef enum {S_PRE, S_HDR, S_TA, S_DATA} smp_dev_state_t;
  smp_dev_state_t state_reg;
  logic [5:0]  cnt_reg;
  logic [13:0] hdr_reg;
  logic [15:0] shift_reg;
  logic        rd_reg;
  logic        match_reg;
  logic        wr_strobe;
  logic [15:0] wdata;
  logic        oe_reg;
  logic        o_reg;
  logic [15:0] rdata;
  logic [13:0] hdr_next;
  logic        mdio_s;
  assign mdio_s   = bus.mdio;
  assign hdr_next = {hdr_reg[12:0], mdio_s};
  // write lands on the edge that samples the last data bit: the clock stops after a frame
  assign wr_strobe = state_reg == S_DATA && cnt_reg == 6'(smp_pkg::DATA_BITS - 1)
                     && match_reg && !rd_reg;
  assign wdata     = {shift_reg[14:0], mdio_s};
  smp_regfile u_regs (
    .clk_in    (bus.mdc),
    .rst_n_in  (rst_n_in),
    .we_in     (wr_strobe),
    .addr_in   (hdr_reg[4:0]),
    .wdata_in  (wdata),
    .rdata_out (rdata)
  );
  // frame decoder sampling on the rising edge
  always_ff @(posedge bus.mdc or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= S_PRE;
      cnt_reg   <= 6'h00;
      hdr_reg   <= 14'h0000;
      shift_reg <= 16'h0000;
      rd_reg    <= 1'b0;
      match_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        S_PRE:
        begin
          if (mdio_s)
            cnt_reg <= (cnt_reg == 6'(smp_pkg::PRE_BITS)) ? cnt_reg : cnt_reg + 6'h01;
          else if (cnt_reg == 6'(smp_pkg::PRE_BITS))
          begin
            state_reg <= S_HDR;
            cnt_reg   <= 6'h00;
            hdr_reg   <= 14'h0000;
          end
          else
            cnt_reg <= 6'h00;
        end
        S_HDR:
        begin
          hdr_reg <= hdr_next;
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == 6'h00 && !mdio_s)
          begin
            state_reg <= S_PRE; // start code must be 01
            cnt_reg   <= 6'h00;
          end
          else if (cnt_reg == 6'd12)
          begin
            // bit layout: start1 op[1:0] phy[4:0] reg[4:0]
            rd_reg    <= hdr_next[11:10] == smp_pkg::OP_READ;
            match_reg <= (hdr_next[9:5] == smp_pkg::PHY_ADDR)
                         && (hdr_next[11:10] == smp_pkg::OP_READ
                             || hdr_next[11:10] == smp_pkg::OP_WRITE);
            shift_reg <= rdata;
            state_reg <= S_TA;
            cnt_reg   <= 6'h00;
          end
        end
        S_TA:
        begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == 6'h00)
            shift_reg <= rdata;
          if (cnt_reg == 6'h01)
          begin
            state_reg <= S_DATA;
            cnt_reg   <= 6'h00;
          end
        end
        S_DATA:
        begin
          cnt_reg <= cnt_reg + 6'h01;
          if (!rd_reg)
            shift_reg <= {shift_reg[14:0], mdio_s};
          else
            shift_reg <= {shift_reg[14:0], 1'b0};
          if (cnt_reg == 6'(smp_pkg::DATA_BITS - 1))
          begin
            state_reg <= S_PRE;
            cnt_reg   <= 6'h00;
          end
        end
        default:
          state_reg <= S_PRE;
      endcase
    end
  end
  // driver updated on falling edge so the bit is stable by the next rising edge
  always_ff @(negedge bus.mdc or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      oe_reg <= 1'b0;
      o_reg  <= 1'b1;
    end
    else if (match_reg && rd_reg && state_reg == S_TA && cnt_reg == 6'h01)
    begin
      oe_reg <= 1'b1;
      o_reg  <= 1'b0;
    end
    else if (match_reg && rd_reg && state_reg == S_DATA)
    begin
      oe_reg <= 1'b1;
      o_reg  <= shift_reg[15];
    end
    else
    begin
      oe_reg <= 1'b0;
      o_reg  <= 1'b1;
    end
  end
  always_ff @(posedge bus.mdc or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      last_reg_out <= 5'h00;
      wr_seen_out  <= 1'b0;
    end
    else
    begin
      wr_seen_out <= wr_strobe;
      if (wr_strobe)
        last_reg_out <= hdr_reg[4:0];
    end
  end
  assign bus.dev_mdio_oe = oe_reg;
  assign bus.dev_mdio_o  = o_reg;
endmodule : smp_device

//--- smp_station.sv
// station end: makes the management clock by dividing its own clock, runs frames
// assumes user holds request fields stable while start is taken
`timescale 1ns/1ps
module smp_station (
  smp_if.station            bus,
  input  wire logic         clock_in,
  input  wire logic         rst_n_in,
  input  wire logic         start_in,
  input  wire logic         read_in,
  input  wire logic [4:0]   phy_in,
  input  wire logic [4:0]   reg_in,
  input  wire logic [15:0]  wdata_in,
  output logic              busy_out,
  output logic              done_out,
  output logic [15:0]       rdata_out
);
  logic [7:0]  div_reg;
  logic        mdc_reg;
  logic [6:0]  bit_reg;
  logic [63:0] frm_reg;
  logic [63:0] oe_map_reg;
  logic        oe_reg;
  logic        o_reg;
  logic        busy_reg;
  logic        m1_reg;
  logic        m2_reg;
  logic        rise;
  logic        fall;
  assign rise = div_reg == 8'(smp_pkg::MDC_HALF - 1) && !mdc_reg;
  assign fall = div_reg == 8'(smp_pkg::MDC_HALF - 1) && mdc_reg;
  // clock divider, runs only during a frame
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_reg <= 8'h00;
      mdc_reg <= 1'b0;
    end
    else if (!busy_reg)
    begin
      div_reg <= 8'h00;
      mdc_reg <= 1'b0;
    end
    else if (div_reg == 8'(smp_pkg::MDC_HALF - 1))
    begin
      div_reg <= 8'h00;
      mdc_reg <= !mdc_reg;
    end
    else
      div_reg <= div_reg + 8'h01;
  end
  // line sampled through two flip-flops
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      m1_reg <= 1'b1;
      m2_reg <= 1'b1;
    end
    else
    begin
      m1_reg <= bus.mdio;
      m2_reg <= m1_reg;
    end
  end
  // frame sequencer: bits change on falling edges, whole frame without pause
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy_reg   <= 1'b0;
      done_out   <= 1'b0;
      bit_reg    <= 7'h00;
      frm_reg    <= 64'h0000_0000_0000_0000;
      oe_map_reg <= 64'h0000_0000_0000_0000;
      oe_reg     <= 1'b0;
      o_reg      <= 1'b1;
      rdata_out  <= 16'h0000;
    end
    else
    begin
      done_out <= 1'b0;
      if (!busy_reg && start_in)
      begin
        busy_reg <= 1'b1;
        bit_reg  <= 7'h00;
        frm_reg  <= {32'hFFFF_FFFF, smp_pkg::START_CODE,
                     read_in ? smp_pkg::OP_READ : smp_pkg::OP_WRITE,
                     phy_in, reg_in,
                     read_in ? 2'h0 : smp_pkg::TA_WRITE,
                     read_in ? 16'h0000 : wdata_in};
        oe_map_reg <= {46'h3FFF_FFFF_FFFF, read_in ? 18'h0_0000 : 18'h3_FFFF};
        oe_reg   <= 1'b1;
        o_reg    <= 1'b1;
      end
      else if (busy_reg && fall)
      begin
        if (bit_reg == 7'd63)
        begin
          busy_reg <= 1'b0;
          done_out <= 1'b1;
          oe_reg   <= 1'b0;
          o_reg    <= 1'b1;
        end
        else
        begin
          bit_reg    <= bit_reg + 7'h01;
          frm_reg    <= {frm_reg[62:0], 1'b0};
          oe_map_reg <= {oe_map_reg[62:0], 1'b0};
          oe_reg     <= oe_map_reg[62];
          o_reg      <= frm_reg[62];
        end
      end
      else if (busy_reg && rise && bit_reg >= 7'd48)
        rdata_out <= {rdata_out[14:0], m2_reg};
    end
  end
  assign busy_out        = busy_reg;
  assign bus.mdc         = mdc_reg;
  assign bus.sta_mdio_oe = oe_reg;
  assign bus.sta_mdio_o  = o_reg;
endmodule : smp_station

//--- smp_props.sv
// checker watching the management line between station and device
// assumes it is given the raw interface signals and the shared reset
`timescale 1ns/1ps
module smp_props (
  input wire logic mdc,
  input wire logic sta_mdio_o,
  input wire logic sta_mdio_oe,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe,
  input wire logic mdio,
  input wire logic rst_n_in
);
  logic       armed_reg;
  logic [6:0] pos_reg;
  logic [4:0] sh_reg;
  logic [1:0] op_reg;
  logic       mine_reg;
  logic [6:0] idx;
  logic       rd;
  assign idx = (sta_mdio_oe && !armed_reg) ? 7'h00 : pos_reg;
  assign rd  = (op_reg == smp_pkg::OP_READ);
  // cleared when the station lets go, so the next frame restarts the count
  always_ff @(posedge mdc or negedge rst_n_in or negedge sta_mdio_oe)
    if (!rst_n_in || !sta_mdio_oe) armed_reg <= 1'b0;
    else armed_reg <= 1'b1;
  always_ff @(posedge mdc or negedge rst_n_in)
    if (!rst_n_in) pos_reg <= 7'h00;
    else pos_reg <= (idx == 7'h7f) ? idx : idx + 7'h01;
  always_ff @(posedge mdc)
    sh_reg <= {sh_reg[3:0], mdio};
  always_ff @(posedge mdc)
    if (idx == 7'd36) op_reg <= sh_reg[1:0];
  always_ff @(posedge mdc)
    if (idx == 7'd41) mine_reg <= (sh_reg == smp_pkg::PHY_ADDR);
  default clocking @(posedge mdc); endclocking
  default disable iff (!rst_n_in);
  a_pre_ones: assert property (sta_mdio_oe && idx < 7'd32 |-> mdio && sta_mdio_o)
    else $error("preamble bit not one");
  a_start_code: assert property (idx == 7'd32 |-> !mdio ##1 mdio)
    else $error("start code not 01");
  a_op_legal: assert property (idx == 7'd36 |-> sh_reg[1:0] inside {2'b10, 2'b01})
    else $error("opcode neither read nor write");
  a_write_turn: assert property (
    idx == 7'd46 && op_reg == smp_pkg::OP_WRITE
    |-> sta_mdio_oe && mdio ##1 sta_mdio_oe && !mdio)
    else $error("write turnaround not 10");
  a_turn_release: assert property (
    idx == 7'd46 && rd |-> !sta_mdio_oe && !dev_mdio_oe)
    else $error("line driven in first turnaround bit");
  a_turn_low: assert property (
    idx == 7'd47 && rd && mine_reg |-> dev_mdio_oe && !mdio)
    else $error("device did not drive turnaround low");
  a_data_driven: assert property (
    idx > 7'd47 && idx < 7'd64 && rd && mine_reg |-> dev_mdio_oe && !sta_mdio_oe)
    else $error("read data not driven by device");
  a_dev_window: assert property (
    dev_mdio_oe |-> idx > 7'd46 && idx < 7'd64 && rd && mine_reg)
    else $error("device drove outside its read answer");
  a_no_clash: assert property (!(sta_mdio_oe && dev_mdio_oe))
    else $error("both ends drive the line");
  a_idle_high: assert property (!sta_mdio_oe && !dev_mdio_oe |-> mdio && dev_mdio_o)
    else $error("released line not high");
  c_read_answer: cover property (idx == 7'd47 && dev_mdio_oe);
  c_write_frame: cover property (idx == 7'd46 && op_reg == smp_pkg::OP_WRITE);
  c_foreign: cover property (idx == 7'd47 && !mine_reg);
endmodule : smp_props

//--- tb_top.sv
// self-checking bench: station and device joined over one management line
// assumes a 100 MHz clock_in that the station divides for the line clock
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic rd; logic [4:0] phy; logic [4:0] rg; logic [15:0] d;} smp_row_t;
  // d is data sent on writes and data expected on reads
  localparam smp_row_t ROWS [9] = '{
    '{1'b0, 5'h10, 5'h00, 16'ha5a5}, '{1'b0, 5'h10, 5'h1f, 16'h8001},
    '{1'b1, 5'h10, 5'h00, 16'ha5a5}, '{1'b1, 5'h10, 5'h1f, 16'h8001},
    '{1'b0, 5'h03, 5'h0a, 16'h1234}, '{1'b1, 5'h10, 5'h0a, 16'h0000},
    '{1'b1, 5'h0f, 5'h00, 16'hffff}, '{1'b0, 5'h10, 5'h05, 16'h5a5a},
    '{1'b1, 5'h10, 5'h05, 16'h5a5a}};
  logic        clock_in;
  logic        rst_n_in;
  logic        start_in;
  logic        read_in;
  logic [4:0]  phy_in;
  logic [4:0]  reg_in;
  logic [15:0] wdata_in;
  logic        busy;
  logic        done_out;
  logic [15:0] rdata_out;
  logic [4:0]  last_reg;
  logic        wr_seen;
  logic [63:0] frm;
  int          n_errors;
  int          comparisons;
  smp_if bus ();
  smp_station smp_station_i (.bus(bus), .clock_in(clock_in), .rst_n_in(rst_n_in),
    .start_in(start_in), .read_in(read_in), .phy_in(phy_in), .reg_in(reg_in),
    .wdata_in(wdata_in), .busy_out(busy), .done_out(done_out), .rdata_out(rdata_out));
  smp_device smp_device_i (.bus(bus), .rst_n_in(rst_n_in), .last_reg_out(last_reg),
    .wr_seen_out(wr_seen));
  smp_props smp_props_i (.mdc(bus.mdc), .sta_mdio_o(bus.sta_mdio_o),
    .sta_mdio_oe(bus.sta_mdio_oe), .dev_mdio_o(bus.dev_mdio_o),
    .dev_mdio_oe(bus.dev_mdio_oe), .mdio(bus.mdio), .rst_n_in(rst_n_in));
  always @(posedge bus.mdc) frm <= {frm[62:0], bus.mdio};
  task automatic print_verdict;
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic launch(input smp_row_t r);
    start_in = 1'b1;
    read_in  = r.rd;
    phy_in   = r.phy;
    reg_in   = r.rg;
    wdata_in = r.d;
    @(posedge clock_in);
    #1;
    start_in = 1'b0;
    check(busy, 1'b1);
  endtask : launch
  task automatic run(input smp_row_t r);
    logic [1:0]  ta;
    logic [63:0] want;
    int          n;
    ta = (r.rd && r.phy != smp_pkg::PHY_ADDR) ? 2'b11 : smp_pkg::TA_WRITE;
    launch(r);
    n = 0;
    while (done_out !== 1'b1 && n < 3000)
    begin
      @(posedge clock_in);
      #1;
      n++;
    end
    if (n == 3000)
    begin
      n_errors++;
      print_verdict();
    end
    want = {32'hffff_ffff, smp_pkg::START_CODE, r.rd ? smp_pkg::OP_READ : smp_pkg::OP_WRITE,
            r.phy, r.rg, ta, r.d};
    check(frm, want);
    check(wr_seen, !r.rd && r.phy == smp_pkg::PHY_ADDR);
    if (r.rd) check(rdata_out, r.d);
    repeat (2) @(posedge clock_in);
    #1;
  endtask : run
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial
  begin
    {rst_n_in, start_in, read_in, phy_in, reg_in, wdata_in} = '0;
    repeat (12) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    foreach (ROWS[i]) run(ROWS[i]);
    check(last_reg, 5'h05);
    // reset in mid-frame: line released, stored words cleared
    launch(ROWS[3]);
    repeat (600) @(posedge clock_in);
    #1;
    rst_n_in = 1'b0;
    @(posedge clock_in);
    #1;
    check({busy, bus.sta_mdio_oe, bus.dev_mdio_oe, bus.mdc}, 4'h0);
    repeat (3) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    run('{1'b1, 5'h10, 5'h1f, 16'h0000});
    print_verdict();
  end
endmodule : tb_top
